// [bench/acs_analog_model.sv]
// Behavioural model of the analog sample-and-hold and conversion core
`timescale 1ns/100ps
`default_nettype none
module acs_analog_model (
    input  wire logic       clk,
    input  wire logic       start,
    input  wire logic [9:0] value,
    input  wire logic [2:0] lat,
    output logic            done,
    output logic [9:0]      data
);
    logic [2:0] cnt_q;
    // Answers lat+1 cycles after start; data lines show junk outside a sample
    always_ff @(posedge clk) begin
        if (!start) begin
            cnt_q <= 3'h0;
            done  <= 1'b0;
            data  <= ~value;
        end else if (cnt_q >= lat) begin
            done <= 1'b1;
            data <= value;
        end else begin
            cnt_q <= cnt_q + 3'h1;
        end
    end
endmodule
`default_nettype wire

// [bench/tb_adc_control_sequencer.sv]
// Self-checking testbench of the converter sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_adc_control_sequencer;
    import acs_pkg::*;
    logic        CLK = 1'b0;
    logic        RST = 1'b1;
    logic        AVS_READ = 1'b0;
    logic        AVS_WRITE = 1'b0;
    logic [7:0]  AVS_ADDRESS = 8'h00;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [3:0]  AVS_BYTEENABLE = 4'h0;
    logic [31:0] AVS_READDATA;
    logic        AVS_WAITREQUEST, IRQ, SAMPLE_DONE, SAMPLE_START, CONV_CLK;
    logic        ANALOG_ENABLE, SAMPLE_CAP_SELECT, cprev;
    logic [9:0]  SAMPLE_DATA, value = 10'h0, dv;
    logic [2:0]  lat = 3'h0, acc, mode, ini;
    logic [1:0]  REF_SELECT;
    logic [4:0]  INPUT_SELECT, SAMPLE_LENGTH;
    logic [15:0] r, e, lo, hi;
    logic [31:0] v;
    logic [3:0]  sd;
    logic        rs, dith;
    logic        tie_lo = 1'b0, stby = 1'b0;
    int          seed, k, i, n, t0, n_errors = 0, samples_checked = 0;
    logic [7:0]  idx_t [10] = '{IDX_CTRL_A, IDX_ACCUM, IDX_REF_CLOCK_DIVIDER,
        IDX_DELAY, IDX_WINMODE, IDX_SAMPLE_LENGTH, IDX_INSEL, IDX_EVENT,
        IDX_IRQ_EN, 8'h07};
    logic [7:0]  msk_t [10] = '{8'h87, 8'h07, 8'h77, 8'hff, 8'h07, 8'h1f,
        8'h1f, 8'h01, 8'h03, 8'h00};

    always #5 CLK = ~CLK;

    acs_top i_dut (.CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .IRQ(IRQ), .STANDBY(stby), .DEEP_WAKE(tie_lo),
        .START_EVENT(tie_lo), .SAMPLE_DONE(SAMPLE_DONE),
        .SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_START(SAMPLE_START),
        .CONV_CLK(CONV_CLK), .ANALOG_ENABLE(ANALOG_ENABLE),
        .REF_SELECT(REF_SELECT), .SAMPLE_CAP_SELECT(SAMPLE_CAP_SELECT),
        .INPUT_SELECT(INPUT_SELECT), .SAMPLE_LENGTH(SAMPLE_LENGTH));

    acs_analog_model i_core (.clk(CLK), .start(SAMPLE_START), .value(value),
        .lat(lat), .done(SAMPLE_DONE), .data(SAMPLE_DATA));

    // ==========================================================
    // Checking, bus and waiting tasks
    task automatic give_verdict();
        $display("checked %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic hang(input int cnt, input int lim);
        if (cnt >= lim) begin
            n_errors++;
            $display("unexpected at %0t: wait ran out", $time);
            give_verdict();
        end
    endtask

    // Holds the request until waitrequest is seen low at a falling edge
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [15:0] wd);
        int  j;
        logic ok;
        @(posedge CLK);
        AVS_ADDRESS    <= {idx[5:0], 2'b00};
        AVS_WRITEDATA  <= {16'h0, wd};
        AVS_BYTEENABLE <= 4'h3;
        AVS_WRITE      <= wr;
        AVS_READ       <= !wr;
        for (j = 0; j < 20; j++) begin
            @(negedge CLK);
            ok = (AVS_WAITREQUEST === 1'b0);
            if (ok) r = AVS_READDATA[15:0];
            @(posedge CLK);
            if (ok) break;
        end
        AVS_WRITE <= 1'b0;
        AVS_READ  <= 1'b0;
        hang(j, 20);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [15:0] wd);
        bus(1'b1, idx, wd);
    endtask

    task automatic rd(input logic [7:0] idx);
        bus(1'b0, idx, 16'h0);
    endtask

    task automatic wait_irq(input int lim);
        int j;
        for (j = 0; j < lim && IRQ !== 1'b1; j++) @(negedge CLK);
        hang(j, lim);
    endtask

    task automatic chk_irq(input logic exp);
        repeat (2) @(negedge CLK);
        check({15'h0, IRQ}, {15'h0, exp});
    endtask

    function automatic logic win_hit(input logic [2:0] m,
                                     input logic [15:0] x, a, b);
        case (m)
            WIN_BELOW:   return x < a;
            WIN_ABOVE:   return x > b;
            WIN_INSIDE:  return x > a && x < b;
            WIN_OUTSIDE: return x < a || x > b;
            default:     return 1'b0;
        endcase
    endfunction

    // ==========================================================
    // Main sequence
    initial begin
        seed = 32'h19b0;
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
        for (k = 0; k < 10; k++) begin
            rd(idx_t[k]);
            check(r, 16'h0);
            wr(idx_t[k], 16'h00ff);
            rd(idx_t[k]);
            check(r, {8'h0, msk_t[k]});
        end
        check({6'h0, INPUT_SELECT, SAMPLE_LENGTH}, 16'h03ff);
        for (k = 0; k < 10; k++) wr(idx_t[k], 16'h0);
        $display("register test done");
        wr(IDX_CTRL_A, 16'h0001);
        for (k = 0; k < 8; k++) begin
            v = $random(seed);
            wr(IDX_REF_CLOCK_DIVIDER, {9'h0, v[0], 1'b0, v[1], 1'b0, 3'(k)});
            @(negedge CLK);
            check({14'h0, REF_SELECT}, {15'h0, v[1]});
            check({15'h0, SAMPLE_CAP_SELECT}, {15'h0, v[0]});
            n = 0;
            cprev = 1'b1;
            for (i = 0; i < 1200 && n < 3; i++) begin
                @(negedge CLK);
                if (CONV_CLK === 1'b1 && cprev === 1'b0) begin
                    n++;
                    if (n == 3) check(16'(i - t0), 16'(2 << k));
                    t0 = i;
                end
                cprev = CONV_CLK;
            end
            hang(i, 1200);
        end
        wr(IDX_REF_CLOCK_DIVIDER, 16'h0);
        $display("divider test done");
        for (k = 0; k < 8; k++) begin
            v = $random(seed);
            acc = (k == 0) ? ACC_MAX : {1'b0, v[1:0]};
            rs = v[2];
            dv = (k == 0) ? 10'h3ff : v[12:3];
            sd = v[19:16];
            dith = v[20];
            ini = (k == 0) ? 3'h1 : 3'h0;
            mode = 3'(k % 5);
            n = 1 << acc;
            e = 16'(n * (rs ? {2'b0, dv[9:2]} : dv));
            lo = e - 16'h1 + {14'h0, v[22:21]};
            hi = lo + {14'h0, v[24:23]};
            value <= dv;
            lat <= v[27:25];
            wr(IDX_ACCUM, {13'h0, acc});
            wr(IDX_WINMODE, {13'h0, mode});
            wr(IDX_WIN_LOW, lo);
            wr(IDX_WIN_HIGH, hi);
            wr(IDX_DELAY, {8'h0, ini, dith, sd});
            wr(IDX_IRQ_EN, 16'h0003);
            wr(IDX_CTRL_A, {13'h0, rs, 2'b01});
            wr(IDX_COMMAND, 16'h0001);
            if (acc > 3'h1) begin
                rd(IDX_COMMAND);
                check(r, 16'h0001);
            end
            wait_irq(20000);
            rd(IDX_COMMAND);
            check(r, 16'h0000);
            rd(IDX_IRQ_FLAGS);
            check(r, {14'h0, win_hit(mode, e, lo, hi), 1'b1});
            if (k[0]) begin
                wr(IDX_IRQ_EN, 16'h0);
                chk_irq(1'b0);
                wr(IDX_IRQ_EN, 16'h0001);
                chk_irq(1'b1);
                wr(IDX_IRQ_FLAGS, 16'h0);
                chk_irq(1'b1);
                wr(IDX_IRQ_FLAGS, 16'h0003);
                chk_irq(1'b0);
            end
            rd(IDX_RESULT);
            check(r, e);
            rd(IDX_IRQ_FLAGS);
            check(r, 16'h0);
            chk_irq(1'b0);
            rd(IDX_DELAY);
            check(r, {8'h0, ini, dith, sd + (dith ? n[3:0] : 4'h0)});
        end
        $display("conversion test done");
        wr(IDX_ACCUM, 16'h0);
        wr(IDX_WINMODE, 16'h0);
        wr(IDX_DELAY, 16'h000f);
        lat <= 3'h7;
        wr(IDX_CTRL_A, 16'h0003);
        wr(IDX_COMMAND, 16'h0001);
        wait_irq(5000);
        wr(IDX_IRQ_FLAGS, 16'h0003);
        chk_irq(1'b0);
        wait_irq(5000);
        rd(IDX_IRQ_FLAGS);
        check(r, 16'h0001);
        wr(IDX_CTRL_A, 16'h0);
        repeat (300) @(posedge CLK);
        wr(IDX_IRQ_FLAGS, 16'h0003);
        repeat (300) @(posedge CLK);
        rd(IDX_IRQ_FLAGS);
        check(r, 16'h0);
        $display("continuous test done");
        stby <= 1'b1;
        wr(IDX_CTRL_A, 16'h0001);
        repeat (3) @(negedge CLK);
        check({15'h0, ANALOG_ENABLE}, 16'h0000);
        wr(IDX_CTRL_A, 16'h0081);
        @(negedge CLK);
        check({15'h0, ANALOG_ENABLE}, 16'h0001);
        stby <= 1'b0;
        $display("standby test done");
        give_verdict();
    end
endmodule
`default_nettype wire

// [hdl/acs_top.sv]
// Control and sequencing logic of a 10-bit successive-approximation converter
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - The converter runs only while the enable bit is set.
// - Resolution select one drops the two low bits of each sample before use.
// - Continuous mode starts on command and then restarts after each result.
// - With keepalive clear the converter is held idle in standby sleep.
// - The accumulation count code selects 1 to 64 samples, code 7 reserved.
// - All selected samples sum into one result per conversion.
// - Reference select picks internal reference or supply.
// - The sample capacitor bit drives the analog capacitor selection.
// - The divider code divides the peripheral clock by two to 256.
// - Enabling or moving to internal reference waits the startup delay.
// - Waking from deep sleep also waits the startup delay.
// - Dither increments the inter-sample delay after each sample.
// - Each inter-sample gap lasts the delay field in converter clocks.
// - The window mode sets the match flag per comparison condition.
// - Writing start begins a measurement and reads one while busy.
// - Flags clear on write of one or on result read, zero writes ignored.
module acs_top
    import acs_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [7:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    output logic             IRQ,
    input  wire logic        STANDBY,
    input  wire logic        DEEP_WAKE,
    input  wire logic        START_EVENT,
    input  wire logic        SAMPLE_DONE,
    input  wire logic [9:0]  SAMPLE_DATA,
    output logic             SAMPLE_START,
    output logic             CONV_CLK,
    output logic             ANALOG_ENABLE,
    output logic [1:0]       REF_SELECT,
    output logic             SAMPLE_CAP_SELECT,
    output logic [4:0]       INPUT_SELECT,
    output logic [4:0]       SAMPLE_LENGTH
);
    // ==========================================================
    // Registers
    acs_ctrl_type  ctrl_q;
    logic [7:0]    accum_q, refp_q, delay_q, winm_q, sample_length_q, insel_q;
    logic [7:0]    event_q, irqen_q, debug_q, staging_q, duty_cycle_calibration_q;
    logic [15:0]   result_q, winlo_q, winhi_q, acc_q;
    logic [1:0]    flags_q;
    logic          busy_q, rd_ack_q, need_init_q, wake_q;
    logic [2:0]    ev_sync_q, wk_sync_q;
    logic [1:0]    sb_sync_q;
    logic [7:0]    div_q;
    logic [8:0]    cnt_q;
    logic [6:0]    nsamp_q;
    acs_state_type st_q;

    // Writes land only at the edge that ends the cycle after the wait state
    wire       wr  = AVS_WRITE & AVS_BYTEENABLE[0] & rd_ack_q;
    wire [7:0] wd  = AVS_WRITEDATA[7:0];
    wire [7:0] idx = {2'b00, AVS_ADDRESS[7:2]};
    wire       hi  = AVS_BYTEENABLE[1];
    wire       wr_ctrl = wr && idx == IDX_CTRL_A;
    wire       wr_cmd  = wr && idx == IDX_COMMAND;
    wire       wr_flag = wr && idx == IDX_IRQ_FLAGS;
    wire       rd_res  = AVS_READ && !rd_ack_q && idx == IDX_RESULT;

    // ==========================================================
    // Converter clock divider
    wire [7:0] div_mask  = 8'(({1'b0, 8'h02} << refp_q[2:0]) - 9'h001);
    wire       adc_tick  = (div_q & div_mask) == div_mask;
    wire       run_ok    = ctrl_q.enable && !(sb_sync_q[1] &&
                           !ctrl_q.keepalive);
    wire       ev_rise   = ev_sync_q[1] && !ev_sync_q[2] && event_q[0];
    wire       wake_rise = wk_sync_q[1] && !wk_sync_q[2];
    wire       start_req = wr_cmd && wd[0] || ev_rise;
    wire [8:0] init_len  = (delay_q[7:5] == 3'h0 || delay_q[7:5] > INIT_MAX) ?
                           9'h000 : 9'(9'h008 << delay_q[7:5]);
    wire [6:0] acc_len   = (accum_q[2:0] > ACC_MAX) ? 7'h01 :
                           7'(7'h01 << accum_q[2:0]);
    wire [9:0] samp_trim = ctrl_q.res_sel ? {2'b00, SAMPLE_DATA[9:2]} :
                           SAMPLE_DATA;
    wire [15:0] acc_sum  = acc_q + {6'h00, samp_trim};
    wire       last_samp = nsamp_q == acc_len - 7'h01;
    // Zero and reserved startup codes go straight to sampling
    wire       init_owed  = need_init_q && init_len != 9'h000;
    wire       leave_idle = run_ok && st_q == ST_IDLE &&
                            (busy_q || start_req);

    // Window comparison on the finished result
    wire lt = acc_sum < winlo_q;
    wire gt = acc_sum > winhi_q;
    logic win_hit;
    always_comb begin
        case (winm_q[2:0])
            WIN_BELOW:   win_hit = lt;
            WIN_ABOVE:   win_hit = gt;
            WIN_INSIDE:  win_hit = (acc_sum > winlo_q) && (acc_sum < winhi_q);
            WIN_OUTSIDE: win_hit = lt || gt;
            default:     win_hit = 1'b0;
        endcase
    end
    wire conv_end = st_q == ST_SAMPLE && SAMPLE_DONE && adc_tick && last_samp;

    // ==========================================================
    // Sequencer
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_q     <= ST_IDLE;
            cnt_q    <= 9'h000;
            nsamp_q  <= 7'h00;
            acc_q    <= RESET_WORD;
            busy_q   <= 1'b0;
            div_q    <= 8'h00;
        end else begin
            div_q <= (run_ok && !adc_tick) ? div_q + 8'h01 : 8'h00;
            if (!run_ok) begin
                st_q   <= ST_IDLE;
                busy_q <= 1'b0;
            end else begin
                if (start_req)
                    busy_q <= 1'b1;
                case (st_q)
                    ST_IDLE: if (busy_q || start_req) begin
                        st_q    <= init_owed ? ST_INIT : ST_SAMPLE;
                        cnt_q   <= init_len;
                        nsamp_q <= 7'h00;
                        acc_q   <= RESET_WORD;
                    end
                    ST_INIT: if (adc_tick) begin
                        if (cnt_q <= 9'h001)
                            st_q <= ST_SAMPLE;
                        cnt_q <= cnt_q - 9'h001;
                    end
                    ST_SAMPLE: if (adc_tick && SAMPLE_DONE) begin
                        acc_q   <= acc_sum;
                        nsamp_q <= nsamp_q + 7'h01;
                        cnt_q   <= {5'h00, delay_q[3:0]};
                        if (last_samp) begin
                            st_q <= ST_DONE;
                        end else if (delay_q[3:0] != 4'h0) begin
                            st_q <= ST_DELAY;
                        end
                    end
                    ST_DELAY: if (adc_tick) begin
                        if (cnt_q <= 9'h001)
                            st_q <= ST_SAMPLE;
                        cnt_q <= cnt_q - 9'h001;
                    end
                    ST_DONE: begin
                        nsamp_q <= 7'h00;
                        acc_q   <= RESET_WORD;
                        if (ctrl_q.cont_conv) begin
                            st_q <= ST_SAMPLE;
                        end else begin
                            st_q   <= ST_IDLE;
                            busy_q <= start_req;
                        end
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end

    // Startup delay is owed after enable, internal ref change, or wake
    wire ref_to_int = wr && idx == IDX_REF_CLOCK_DIVIDER &&
                      wd[5:4] == REF_INTERNAL && refp_q[5:4] != REF_INTERNAL;
    wire en_rise    = wr_ctrl && wd[0] && !ctrl_q.enable;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            need_init_q <= 1'b1;
            wake_q      <= 1'b0;
        end else if (en_rise || ref_to_int || wake_rise) begin
            need_init_q <= 1'b1;
            wake_q      <= wake_rise;
        end else if (leave_idle) begin
            need_init_q <= 1'b0;
            wake_q      <= 1'b0;
        end
    end

    // ==========================================================
    // Synchronisers for pin inputs
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ev_sync_q <= 3'h0;
            wk_sync_q <= 3'h0;
            sb_sync_q <= 2'h0;
        end else begin
            ev_sync_q <= {ev_sync_q[1:0], START_EVENT};
            wk_sync_q <= {wk_sync_q[1:0], DEEP_WAKE};
            sb_sync_q <= {sb_sync_q[0], STANDBY};
        end
    end
    wire unused_ok = wake_q;

    // ==========================================================
    // Register writes
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_q <= '0;
            {accum_q, refp_q, winm_q, sample_length_q} <= {4{RESET_BYTE}};
            {insel_q, event_q, irqen_q, debug_q} <= {4{RESET_BYTE}};
            {staging_q, duty_cycle_calibration_q}                 <= {2{RESET_BYTE}};
            {winlo_q, winhi_q, result_q}         <= {3{RESET_WORD}};
        end else begin
            if (wr_ctrl)
                ctrl_q <= {wd[7], wd[2:0]};
            if (wr && idx == IDX_ACCUM)     accum_q   <= wd & MASK_ACCUM;
            if (wr && idx == IDX_REF_CLOCK_DIVIDER) refp_q    <= wd & MASK_REF_CLOCK_DIVIDER;
            if (wr && idx == IDX_WINMODE)   winm_q    <= wd & MASK_WINMODE;
            if (wr && idx == IDX_SAMPLE_LENGTH)   sample_length_q <= wd & MASK_FIVE_BIT;
            if (wr && idx == IDX_INSEL && !busy_q)
                insel_q <= wd & MASK_FIVE_BIT;
            if (wr && idx == IDX_EVENT)     event_q   <= wd & MASK_BIT0;
            if (wr && idx == IDX_IRQ_EN)    irqen_q   <= wd & MASK_IRQ;
            if (wr && idx == IDX_DEBUG)     debug_q   <= wd & MASK_BIT0;
            if (wr && idx == IDX_STAGING)   staging_q <= wd;
            if (wr && idx == IDX_DUTY_CYCLE_CALIBRATION)     duty_cycle_calibration_q   <= wd & MASK_BIT0;
            if (wr && idx == IDX_WIN_LOW)
                winlo_q <= {hi ? AVS_WRITEDATA[15:8] : winlo_q[15:8], wd};
            if (wr && idx == IDX_WIN_HIGH)
                winhi_q <= {hi ? AVS_WRITEDATA[15:8] : winhi_q[15:8], wd};
            if (conv_end)
                result_q <= acc_sum;
        end
    end

    // Delay field and flags: a delay write beats the dither step, hardware flag set wins over clear
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            delay_q <= RESET_BYTE;
            flags_q <= 2'b00;
        end else begin
            if (wr && idx == IDX_DELAY)
                delay_q <= wd;
            else if (st_q == ST_SAMPLE && adc_tick && SAMPLE_DONE &&
                     delay_q[4])
                delay_q[3:0] <= delay_q[3:0] + 4'h1;
            flags_q <= (flags_q & ~((wr_flag ? wd[1:0] : 2'b00) |
                        {2{rd_res}})) | {conv_end && win_hit, conv_end};
        end
    end

    // ==========================================================
    // Avalon slave: one wait cycle per access
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rd_ack_q     <= 1'b0;
            AVS_READDATA <= 32'h00000000;
        end else begin
            rd_ack_q <= (AVS_READ || AVS_WRITE) && !rd_ack_q;
            case (idx)
                IDX_CTRL_A:    AVS_READDATA <= {24'h0, ctrl_q.keepalive,
                                   4'h0, ctrl_q.res_sel, ctrl_q.cont_conv,
                                   ctrl_q.enable};
                IDX_ACCUM:     AVS_READDATA <= {24'h0, accum_q};
                IDX_REF_CLOCK_DIVIDER: AVS_READDATA <= {24'h0, refp_q};
                IDX_DELAY:     AVS_READDATA <= {24'h0, delay_q};
                IDX_WINMODE:   AVS_READDATA <= {24'h0, winm_q};
                IDX_SAMPLE_LENGTH:   AVS_READDATA <= {24'h0, sample_length_q};
                IDX_INSEL:     AVS_READDATA <= {24'h0, insel_q};
                IDX_COMMAND:   AVS_READDATA <= {31'h0, busy_q};
                IDX_EVENT:     AVS_READDATA <= {24'h0, event_q};
                IDX_IRQ_EN:    AVS_READDATA <= {24'h0, irqen_q};
                IDX_IRQ_FLAGS: AVS_READDATA <= {30'h0, flags_q};
                IDX_DEBUG:     AVS_READDATA <= {24'h0, debug_q};
                IDX_STAGING:   AVS_READDATA <= {24'h0, staging_q};
                IDX_RESULT:    AVS_READDATA <= {16'h0, result_q};
                IDX_WIN_LOW:   AVS_READDATA <= {16'h0, winlo_q};
                IDX_WIN_HIGH:  AVS_READDATA <= {16'h0, winhi_q};
                IDX_DUTY_CYCLE_CALIBRATION:     AVS_READDATA <= {24'h0, duty_cycle_calibration_q};
                default:       AVS_READDATA <= 32'h00000000;
            endcase
        end
    end

    assign AVS_WAITREQUEST   = (AVS_READ || AVS_WRITE) && !rd_ack_q;
    assign IRQ               = |(flags_q & irqen_q[1:0]);
    assign SAMPLE_START      = st_q == ST_SAMPLE && !unused_ok;
    assign CONV_CLK          = div_q[7:0] > (div_mask >> 1);
    assign ANALOG_ENABLE     = run_ok;
    assign REF_SELECT        = refp_q[5:4];
    assign SAMPLE_CAP_SELECT = refp_q[6];
    assign INPUT_SELECT      = insel_q[4:0];
    assign SAMPLE_LENGTH     = sample_length_q[4:0];

    // ==========================================================
    // Sequences for multi-step checks
    sequence s_sample_taken;
        st_q == ST_SAMPLE && adc_tick && SAMPLE_DONE;
    endsequence
    sequence s_gap_open;
        st_q == ST_DELAY && !SAMPLE_START;
    endsequence

    // ==========================================================
    // Assertions
    a_flag_set_end: assert property (@(posedge CLK) disable iff (RST)
        conv_end |=> flags_q[0]) else $error("ready flag not set");
    a_disable_idle: assert property (@(posedge CLK) disable iff (RST)
        !run_ok |=> st_q == ST_IDLE) else $error("disabled but active");
    a_standby_hold: assert property (@(posedge CLK) disable iff (RST)
        sb_sync_q[1] && !ctrl_q.keepalive |-> !ANALOG_ENABLE)
        else $error("runs in standby");
    a_cont_restart: assert property (@(posedge CLK) disable iff (RST)
        st_q == ST_DONE && ctrl_q.cont_conv && run_ok |=> st_q == ST_SAMPLE)
        else $error("no restart");
    a_trim_low: assert property (@(posedge CLK) disable iff (RST)
        ctrl_q.res_sel |-> samp_trim[9:8] == 2'b00)
        else $error("trim wrong");
    a_busy_read: assert property (@(posedge CLK) disable iff (RST)
        st_q inside {ST_INIT, ST_SAMPLE, ST_DELAY} && run_ok |-> busy_q)
        else $error("busy low");
    a_flag_clear: assert property (@(posedge CLK) disable iff (RST)
        rd_res && !conv_end |=> !flags_q[0]) else $error("no clear");
    a_ref_drive: assert property (@(posedge CLK) disable iff (RST)
        wr && idx == IDX_REF_CLOCK_DIVIDER |=> REF_SELECT == $past(wd[5:4]) &&
        SAMPLE_CAP_SELECT == $past(wd[6])) else $error("ref pins");
    a_dither_step: assert property (@(posedge CLK) disable iff (RST)
        st_q == ST_SAMPLE && adc_tick && SAMPLE_DONE && delay_q[4] && !wr
        |=> delay_q[3:0] == $past(delay_q[3:0]) + 4'h1)
        else $error("dither");
    a_gap_entry: assert property (@(posedge CLK) disable iff (RST)
        s_sample_taken ##0 (!last_samp && delay_q[3:0] != 4'h0 && run_ok)
        |=> s_gap_open) else $error("no sample gap");
    a_gap_end: assert property (@(posedge CLK) disable iff (RST)
        s_gap_open ##0 (adc_tick && cnt_q <= 9'h001 && run_ok)
        |=> st_q == ST_SAMPLE) else $error("gap too long");
    a_tick_spacing: assert property (@(posedge CLK) disable iff (RST)
        adc_tick |=> !adc_tick)
        else $error("converter clock too fast");
    a_init_first: assert property (@(posedge CLK) disable iff (RST)
        leave_idle && init_owed |=> st_q == ST_INIT)
        else $error("startup delay skipped");
    a_acc_reserved: assert property (@(posedge CLK) disable iff (RST)
        accum_q[2:0] == 3'h7 |-> acc_len == 7'h01)
        else $error("reserved count");
endmodule
`default_nettype wire

// [inc/acs_pkg.sv]
// Register map, field layout and timing constants of the converter sequencer
package acs_pkg;
    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [7:0] IDX_CTRL_A    = 8'h00;
    localparam logic [7:0] IDX_ACCUM     = 8'h01;
    localparam logic [7:0] IDX_REF_CLOCK_DIVIDER = 8'h02;
    localparam logic [7:0] IDX_DELAY     = 8'h03;
    localparam logic [7:0] IDX_WINMODE   = 8'h04;
    localparam logic [7:0] IDX_SAMPLE_LENGTH   = 8'h05;
    localparam logic [7:0] IDX_INSEL     = 8'h06;
    localparam logic [7:0] IDX_COMMAND   = 8'h08;
    localparam logic [7:0] IDX_EVENT     = 8'h09;
    localparam logic [7:0] IDX_IRQ_EN    = 8'h0a;
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0b;
    localparam logic [7:0] IDX_DEBUG     = 8'h0c;
    localparam logic [7:0] IDX_STAGING   = 8'h0d;
    localparam logic [7:0] IDX_RESULT    = 8'h10;
    localparam logic [7:0] IDX_WIN_LOW   = 8'h12;
    localparam logic [7:0] IDX_WIN_HIGH  = 8'h14;
    localparam logic [7:0] IDX_DUTY_CYCLE_CALIBRATION     = 8'h16;
    // ==========================================================
    // Writable masks per register; other bits read zero
    localparam logic [7:0] MASK_CTRL_A    = 8'h87;
    localparam logic [7:0] MASK_ACCUM     = 8'h07;
    localparam logic [7:0] MASK_REF_CLOCK_DIVIDER = 8'h77;
    localparam logic [7:0] MASK_WINMODE   = 8'h07;
    localparam logic [7:0] MASK_FIVE_BIT  = 8'h1f;
    localparam logic [7:0] MASK_BIT0      = 8'h01;
    localparam logic [7:0] MASK_IRQ       = 8'h03;
    localparam logic [7:0] RESET_BYTE     = 8'h00;
    localparam logic [15:0] RESET_WORD    = 16'h0000;
    // ==========================================================
    // Window compare modes and init codes
    localparam logic [2:0] WIN_NONE    = 3'h0;
    localparam logic [2:0] WIN_BELOW   = 3'h1;
    localparam logic [2:0] WIN_ABOVE   = 3'h2;
    localparam logic [2:0] WIN_INSIDE  = 3'h3;
    localparam logic [2:0] WIN_OUTSIDE = 3'h4;
    localparam logic [2:0] ACC_MAX     = 3'h6;
    localparam logic [2:0] INIT_MAX    = 3'h5;
    localparam logic [1:0] REF_INTERNAL = 2'h0;
    localparam int         ADC_BITS    = 10;

    typedef struct packed {
        logic       keepalive;
        logic       res_sel;
        logic       cont_conv;
        logic       enable;
    } acs_ctrl_type;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_INIT   = 3'b001,
        ST_SAMPLE = 3'b011,
        ST_DELAY  = 3'b010,
        ST_DONE   = 3'b110
    } acs_state_type;
endpackage
